/* inc/erb_pkg.sv */
// package: constants, types and width helpers of the embedded ram block
package erb_pkg;

	// storage: 1024 bytes of 9 bits each
	localparam int ERB_BYTES = 1024;
	localparam int ERB_AW    = 13;
	localparam int ERB_DW    = 36;
	localparam int ERB_BEW   = 4;
	localparam int ERB_PAW   = 12;

	localparam logic [8:0] ERB_INIT_BYTE = 9'h000;
	localparam logic [3:0] ERB_MASK_ALL  = 4'hf;

	// register offsets
	localparam logic [11:0] ERB_CFG_OFFSET  = 12'h000;
	localparam logic [11:0] ERB_STAT_OFFSET = 12'h004;

	// configuration fields
	localparam int ERB_CFG_W           = 14;
	localparam int ERB_CFG_MODE_LSB    = 0;
	localparam int ERB_CFG_WA_LSB      = 2;
	localparam int ERB_CFG_WB_LSB      = 6;
	localparam int ERB_CFG_RDW_NEW_BIT = 10;
	localparam int ERB_CFG_MIX_DC_BIT  = 11;
	localparam int ERB_CFG_OREG_A_BIT  = 12;
	localparam int ERB_CFG_OREG_B_BIT  = 13;
	localparam logic [13:0] ERB_CFG_RESET = 14'h00cc;

	// status fields
	localparam int ERB_STAT_ERR_BIT    = 0;
	localparam int ERB_STAT_COLL_BIT   = 1;
	localparam int ERB_STAT_MASK_A_BIT = 2;
	localparam int ERB_STAT_MASK_B_BIT = 3;

	typedef enum logic [1:0] {
		ERB_SINGLE,
		ERB_SIMPLE,
		ERB_TRUE,
		ERB_PACKED
	} erb_mode_type;

	typedef enum logic [3:0] {
		ERB_W1, ERB_W2, ERB_W4, ERB_W8, ERB_W9,
		ERB_W16, ERB_W18, ERB_W32, ERB_W36
	} erb_width_type;

	function automatic int erb_bits(erb_width_type w);
		unique case (w)
		ERB_W1: return 1;
		ERB_W2: return 2;
		ERB_W4: return 4;
		ERB_W8: return 8;
		ERB_W9: return 9;
		ERB_W16: return 16;
		ERB_W18: return 18;
		ERB_W32: return 32;
		ERB_W36: return 36;
		default: return 0;
		endcase
	endfunction

	function automatic int erb_lanes(erb_width_type w);
		unique case (w)
		ERB_W16, ERB_W18: return 2;
		ERB_W32, ERB_W36: return 4;
		default: return 1;
		endcase
	endfunction

	function automatic logic erb_parity(erb_width_type w);
		return (w == ERB_W9) || (w == ERB_W18) || (w == ERB_W36);
	endfunction

	function automatic logic erb_narrow(erb_width_type w);
		return erb_bits(w) < 8;
	endfunction

	function automatic logic erb_valid(logic [3:0] c);
		return c <= 4'h8;
	endfunction

endpackage

/* core/erb_port.sv */
// one port front end: address register, read latch and output register
`timescale 1ns/1ps
module erb_port (
	// clock and clears
	input  wire logic                      clk,
	input  wire logic                      resetn,
	input  wire logic                      aclr,
	// port controls
	input  wire logic                      ce_in,
	input  wire logic                      ce_out,
	input  wire logic                      addr_hold,
	input  wire logic [erb_pkg::ERB_AW-1:0] addr,
	input  wire logic                      oreg_en,
	// read data from the array
	input  wire logic                      rd_load,
	input  wire logic [erb_pkg::ERB_DW-1:0] rd_value,
	// results
	output wire logic [erb_pkg::ERB_AW-1:0] eff_addr,
	output wire logic [erb_pkg::ERB_DW-1:0] q
);
	import erb_pkg::*;

	logic [ERB_AW-1:0] addr_reg;
	logic [ERB_DW-1:0] q_lat;
	logic [ERB_DW-1:0] q_reg;

	assign eff_addr = addr_hold ? addr_reg : addr;

	always_ff @(posedge clk or posedge aclr) begin
		if (aclr)
			addr_reg <= '0;
		else if (!resetn)
			addr_reg <= '0;
		else if (ce_in)
			addr_reg <= eff_addr;
	end

	always_ff @(posedge clk or posedge aclr) begin
		if (aclr)
			q_lat <= '0;
		else if (!resetn)
			q_lat <= '0;
		else if (rd_load)
			q_lat <= rd_value;
	end

	always_ff @(posedge clk or posedge aclr) begin
		if (aclr)
			q_reg <= '0;
		else if (!resetn)
			q_reg <= '0;
		else if (ce_out)
			q_reg <= q_lat;
	end

	assign q = oreg_en ? q_reg : q_lat;

endmodule

/* core/erb_core.sv */
// embedded ram block: storage array, two ports and apb configuration
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps

// Notes on behaviour
// - 9216 bits stored, 8192 without parity
// - separate read and write enables per port
// - nine shapes, 8192x1 up to 256x36
// - true dual port: any read/write pair
// - true dual port: mixed widths, no x32/x36
// - two clock enables on each port
// - both clock enables off stop all operations but the clear
// - clear only read address and outputs
// - reads and writes on rising edge
// - same-port read-during-write: old or new
// - mixed-port collision: old data, mix_dc has no effect
// - extra bit per byte, no parity logic
// - only enabled byte lanes are written
// - mask defaults to all ones, no clear
// - masking only for 16/18/32/36 widths
// - mask bit 0 is lowest lane
// - masks active high, any combination
// - masked lanes show old data on write
// - true dual port masking needs byte widths
// - packed: two half-size single ports
// - contents loaded with ERB_INIT_BYTE during reset
// - address hold keeps previous address
// - write without read keeps outputs
// - output register delays data one cycle
module erb_core (
	// clock and reset
	input  wire logic                       clk,
	input  wire logic                       resetn,
	// apb slave
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [erb_pkg::ERB_PAW-1:0] paddr,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output wire logic                       pready,
	output wire logic                       pslverr,
	// port a
	input  wire logic                       a_aclr,
	input  wire logic                       a_ce_in,
	input  wire logic                       a_ce_out,
	input  wire logic                       a_addr_hold,
	input  wire logic [erb_pkg::ERB_AW-1:0]  a_addr,
	input  wire logic                       a_rden,
	input  wire logic                       a_wren,
	input  wire logic [erb_pkg::ERB_BEW-1:0] a_byteena,
	input  wire logic [erb_pkg::ERB_DW-1:0]  a_data,
	output wire logic [erb_pkg::ERB_DW-1:0]  a_q,
	// port b
	input  wire logic                       b_aclr,
	input  wire logic                       b_ce_in,
	input  wire logic                       b_ce_out,
	input  wire logic                       b_addr_hold,
	input  wire logic [erb_pkg::ERB_AW-1:0]  b_addr,
	input  wire logic                       b_rden,
	input  wire logic                       b_wren,
	input  wire logic [erb_pkg::ERB_BEW-1:0] b_byteena,
	input  wire logic [erb_pkg::ERB_DW-1:0]  b_data,
	output wire logic [erb_pkg::ERB_DW-1:0]  b_q
);
	import erb_pkg::*;

	logic [8:0]           mem [0:ERB_BYTES-1];
	logic [ERB_CFG_W-1:0] cfg;
	logic                 coll;
	logic [31:0]          stat_word;

	wire erb_mode_type  mode  = erb_mode_type'(cfg[ERB_CFG_MODE_LSB +: 2]);
	wire erb_width_type wa    = erb_width_type'(cfg[ERB_CFG_WA_LSB +: 4]);
	wire erb_width_type wb    = erb_width_type'(cfg[ERB_CFG_WB_LSB +: 4]);
	wire logic          rdw_new = cfg[ERB_CFG_RDW_NEW_BIT];
	wire logic          mix_dc  = cfg[ERB_CFG_MIX_DC_BIT];
	wire logic          packed_on = mode == ERB_PACKED;

	function automatic logic [9:0] base_of(erb_width_type w,
		logic [ERB_AW-1:0] a, logic hi, logic pk);
		logic [9:0] b;
		b = '0;
		unique case (w)
		ERB_W1: b = a[12:3];
		ERB_W2: b = a[11:2];
		ERB_W4: b = a[10:1];
		ERB_W8, ERB_W9: b = a[9:0];
		ERB_W16, ERB_W18: b = {a[8:0], 1'b0};
		default: b = {a[7:0], 2'b00};
		endcase
		if (pk)
			b = {hi, b[8:0]};
		return b;
	endfunction

	// bit position inside a byte for narrow shapes
	function automatic logic [2:0] off_of(erb_width_type w,
		logic [ERB_AW-1:0] a);
		unique case (w)
		ERB_W1: return a[2:0];
		ERB_W2: return {a[1:0], 1'b0};
		ERB_W4: return {a[0], 2'b00};
		default: return 3'h0;
		endcase
	endfunction

	function automatic logic [ERB_DW-1:0] rd_word(erb_width_type w,
		logic [9:0] b, logic [2:0] off);
		logic [ERB_DW-1:0] r;
		r = '0;
		if (erb_narrow(w)) begin
			for (int i = 0; i < 4; i++)
				if (i < erb_bits(w))
					r[i] = mem[b][3'(off + 3'(i))];
		end else begin
			for (int l = 0; l < 4; l++)
				if (l < erb_lanes(w)) begin
					if (erb_parity(w))
						r[l*9 +: 9] = mem[10'(b + 10'(l))];
					else
						r[l*8 +: 8] = mem[10'(b + 10'(l))][7:0];
				end
		end
		return r;
	endfunction

	// old word with the enabled lanes replaced by write data
	function automatic logic [ERB_DW-1:0] merge(erb_width_type w,
		logic [ERB_DW-1:0] old, logic [ERB_DW-1:0] d, logic [3:0] be);
		logic [ERB_DW-1:0] r;
		r = old;
		if (erb_narrow(w)) begin
			for (int i = 0; i < 4; i++)
				if (i < erb_bits(w))
					r[i] = d[i];
		end else begin
			for (int l = 0; l < 4; l++)
				if (l < erb_lanes(w) && be[l]) begin
					if (erb_parity(w))
						r[l*9 +: 9] = d[l*9 +: 9];
					else
						r[l*8 +: 8] = d[l*8 +: 8];
				end
		end
		return r;
	endfunction

	// masking allowed for this width
	function automatic logic mask_ok(erb_width_type w, erb_width_type o,
		erb_mode_type m);
		logic wide;
		wide = (w == ERB_W16) || (w == ERB_W18) ||
			(w == ERB_W32) || (w == ERB_W36);
		return wide && (m != ERB_TRUE || (!erb_narrow(w) &&
			!erb_narrow(o)));
	endfunction

	// configuration legality
	logic cfg_err;
	always_comb begin
		cfg_err = !erb_valid(cfg[ERB_CFG_WA_LSB +: 4]) ||
			!erb_valid(cfg[ERB_CFG_WB_LSB +: 4]);
		unique case (mode)
		ERB_SINGLE: ;
		ERB_SIMPLE:
			if (erb_parity(wa) != erb_parity(wb))
				cfg_err = 1'b1;
		ERB_TRUE:
			if (erb_bits(wa) >= 32 || erb_bits(wb) >= 32 ||
				erb_parity(wa) != erb_parity(wb))
				cfg_err = 1'b1;
		// packed halves up to 18 bits
		ERB_PACKED:
			if (erb_bits(wa) > 18 || erb_bits(wb) > 18)
				cfg_err = 1'b1;
		endcase
	end

	// port roles per mode
	wire logic a_rd_ok = mode != ERB_SIMPLE;
	wire logic b_rd_ok = mode != ERB_SINGLE;
	wire logic b_wr_ok = (mode == ERB_TRUE) || packed_on;

	wire logic a_do_wr = a_ce_in & a_wren;
	wire logic b_do_wr = b_ce_in & b_wren & b_wr_ok;
	wire logic a_do_rd = a_ce_in & a_rden & a_rd_ok;
	wire logic b_do_rd = b_ce_in & b_rden & b_rd_ok;

	wire logic a_mask = mask_ok(wa, wb, mode);
	wire logic b_mask = mask_ok(wb, wa, mode);
	wire logic [3:0] a_be = a_mask ? a_byteena : ERB_MASK_ALL;
	wire logic [3:0] b_be = b_mask ? b_byteena : ERB_MASK_ALL;

	logic [ERB_AW-1:0] a_eff;
	logic [ERB_AW-1:0] b_eff;
	logic [ERB_DW-1:0] a_rdv;
	logic [ERB_DW-1:0] b_rdv;

	// packed port b uses upper half
	wire logic [9:0] a_base = base_of(wa, a_eff, 1'b0, packed_on);
	wire logic [9:0] b_base = base_of(wb, b_eff, 1'b1, packed_on);
	wire logic [2:0] a_off  = off_of(wa, a_eff);
	wire logic [2:0] b_off  = off_of(wb, b_eff);

	erb_port u_port_a (
		.clk      (clk),
		.resetn   (resetn),
		.aclr     (a_aclr),
		.ce_in    (a_ce_in),
		.ce_out   (a_ce_out),
		.addr_hold(a_addr_hold),
		.addr     (a_addr),
		.oreg_en  (cfg[ERB_CFG_OREG_A_BIT]),
		.rd_load  (a_do_rd),
		.rd_value (a_rdv),
		.eff_addr (a_eff),
		.q        (a_q)
	);

	erb_port u_port_b (
		.clk      (clk),
		.resetn   (resetn),
		.aclr     (b_aclr),
		.ce_in    (b_ce_in),
		.ce_out   (b_ce_out),
		.addr_hold(b_addr_hold),
		.addr     (b_addr),
		.oreg_en  (cfg[ERB_CFG_OREG_B_BIT]),
		.rd_load  (b_do_rd),
		.rd_value (b_rdv),
		.eff_addr (b_eff),
		.q        (b_q)
	);

	// read data; the array still holds pre-edge contents here
	always_comb begin
		a_rdv = rd_word(wa, a_base, a_off);
		b_rdv = rd_word(wb, b_base, b_off);
		if (a_do_wr && rdw_new)
			a_rdv = merge(wa, a_rdv, a_data, a_be);
		if (b_do_wr && rdw_new)
			b_rdv = merge(wb, b_rdv, b_data, b_be);
	end

	wire logic [10:0] a_end = 11'(a_base) + 11'(erb_lanes(wa));
	wire logic [10:0] b_end = 11'(b_base) + 11'(erb_lanes(wb));
	wire logic ovl = ({1'b0, a_base} < b_end) && ({1'b0, b_base} < a_end);
	wire logic coll_evt = ovl & ((a_do_wr & b_do_rd) | (b_do_wr & a_do_rd));

	// byte-lane write of one port into the array
	task automatic put(erb_width_type w, logic [9:0] b, logic [2:0] off,
		logic [ERB_DW-1:0] d, logic [3:0] be);
		if (erb_narrow(w)) begin
			for (int i = 0; i < 4; i++)
				if (i < erb_bits(w))
					mem[b][3'(off + 3'(i))] <= d[i];
		end else begin
			for (int l = 0; l < 4; l++)
				if (l < erb_lanes(w) && be[l]) begin
					if (erb_parity(w))
						mem[10'(b + 10'(l))] <= d[l*9 +: 9];
					else
						mem[10'(b + 10'(l))][7:0] <= d[l*8 +: 8];
				end
		end
	endtask

	always_ff @(posedge clk) begin
		if (!resetn) begin
			for (int i = 0; i < ERB_BYTES; i++)
				mem[i] <= ERB_INIT_BYTE;
		end else begin
			if (a_do_wr)
				put(wa, a_base, a_off, a_data, a_be);
			if (b_do_wr)
				put(wb, b_base, b_off, b_data, b_be);
		end
	end

	// apb slave, zero wait states
	wire logic sel_cfg  = paddr == ERB_CFG_OFFSET;
	wire logic sel_stat = paddr == ERB_STAT_OFFSET;
	wire logic hit      = sel_cfg | sel_stat;
	wire logic apb_set  = psel & ~penable;
	wire logic apb_wr   = psel & penable & pwrite & hit;
	wire logic clr_coll = apb_wr & sel_stat & pwdata[ERB_STAT_COLL_BIT];

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~hit;

	always_comb begin
		stat_word = '0;
		stat_word[ERB_STAT_ERR_BIT]    = cfg_err;
		stat_word[ERB_STAT_COLL_BIT]   = coll;
		stat_word[ERB_STAT_MASK_A_BIT] = a_mask;
		stat_word[ERB_STAT_MASK_B_BIT] = b_mask;
	end

	always_ff @(posedge clk) begin
		if (!resetn)
			cfg <= ERB_CFG_RESET;
		else if (apb_wr && sel_cfg)
			cfg <= pwdata[ERB_CFG_W-1:0];
	end

	// collision flag: a new event wins over the clear
	always_ff @(posedge clk) begin
		if (!resetn)
			coll <= 1'b0;
		else
			coll <= (coll & ~clr_coll) | (coll_evt & ~mix_dc) |
				(coll_evt & mix_dc);
	end

	always_ff @(posedge clk) begin
		if (!resetn)
			prdata <= '0;
		else if (apb_set && !pwrite && sel_cfg)
			prdata <= {{(32-ERB_CFG_W){1'b0}}, cfg};
		else if (apb_set && !pwrite && sel_stat)
			prdata <= stat_word;
		else if (apb_set)
			prdata <= '0;
	end

endmodule

/* testbench/erb_core_assertions.sv */
// checker: output relations of the ram block ports
`timescale 1ns/1ps
module erb_chk (
	// clock, reset and bus select
	input  wire logic                       clk,
	input  wire logic                       resetn,
	input  wire logic                       psel,
	// port a
	input  wire logic                       a_aclr,
	input  wire logic                       a_ce_in,
	input  wire logic                       a_ce_out,
	input  wire logic                       a_rden,
	input  wire logic [erb_pkg::ERB_DW-1:0] a_q,
	// port b
	input  wire logic                       b_aclr,
	input  wire logic                       b_ce_in,
	input  wire logic                       b_ce_out,
	input  wire logic                       b_rden,
	input  wire logic [erb_pkg::ERB_DW-1:0] b_q
);
	import erb_pkg::*;
	default clocking @(posedge clk); endclocking
	a_rst_zero_a: assert property (!resetn |=> a_q == '0)
		else $error("a_q not zero after reset");
	b_rst_zero_a: assert property (!resetn |=> b_q == '0)
		else $error("b_q not zero after reset");
	a_clr_zero_a: assert property (disable iff (!resetn)
		a_aclr |-> a_q == '0) else $error("a_q not cleared");
	b_clr_zero_a: assert property (disable iff (!resetn)
		b_aclr |-> b_q == '0) else $error("b_q not cleared");
	a_ce_freeze_a: assert property (disable iff (!resetn)
		(!a_ce_in && !a_ce_out && !a_aclr && !psel ##1 !a_aclr)
		|-> $stable(a_q)) else $error("a_q moved with clocks off");
	b_ce_freeze_a: assert property (disable iff (!resetn)
		(!b_ce_in && !b_ce_out && !b_aclr && !psel ##1 !b_aclr)
		|-> $stable(b_q)) else $error("b_q moved with clocks off");
	a_idle_keep_a: assert property (disable iff (!resetn)
		(!a_rden && a_ce_out && !a_aclr && !psel) [*3]
		|-> $stable(a_q)) else $error("a_q moved without read");
	b_idle_keep_a: assert property (disable iff (!resetn)
		(!b_rden && b_ce_out && !b_aclr && !psel) [*3]
		|-> $stable(b_q)) else $error("b_q moved without read");
endmodule
bind erb_core erb_chk i_chk (.clk, .resetn, .psel, .a_aclr, .a_ce_in,
	.a_ce_out, .a_rden, .a_q, .b_aclr, .b_ce_in, .b_ce_out, .b_rden, .b_q);

/* testbench/erb_fabric.sv */
// partner: fabric user logic driving one ram port
`timescale 1ns/1ps
module erb_fabric (
	// clock
	input  wire logic                  clk,
	// port drive
	output logic                       aclr,
	output logic                       ce,
	output logic                       hold,
	output logic [erb_pkg::ERB_AW-1:0]  addr,
	output logic                       rden,
	output logic                       wren,
	output logic [erb_pkg::ERB_BEW-1:0] be,
	output logic [erb_pkg::ERB_DW-1:0]  data
);
	import erb_pkg::*;
	initial begin
		aclr = 0;
		ce = 1;
		hold = 0;
		addr = '0;
		rden = 0;
		wren = 0;
		be = ERB_MASK_ALL;
		data = '0;
	end
	task automatic op(input logic r, w, c, h, input logic [12:0] a,
		input logic [35:0] d, input logic [3:0] m);
		@(posedge clk);
		rden <= r;
		wren <= w;
		ce <= c;
		hold <= h;
		addr <= a;
		data <= d;
		be <= m;
	endtask
	// released data line shows the inverse, not the last value
	task automatic idle();
		@(posedge clk);
		rden <= 0;
		wren <= 0;
		ce <= 1;
		hold <= 0;
		data <= ~data;
	endtask
	task automatic clr();
		@(posedge clk);
		aclr <= 1;
		@(posedge clk);
		aclr <= 0;
	endtask
endmodule

/* testbench/erb_core_tb_top.sv */
// testbench: random and corner traffic on the ram block
`timescale 1ns/1ps
module erb_core_tb_top;
	import erb_pkg::*;
	logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, rv, seed = 32'h0000_1211;
	logic ev;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, a_ce_out, b_ce_out;
	wire logic a_aclr, a_ce_in, a_addr_hold, a_rden, a_wren;
	wire logic b_aclr, b_ce_in, b_addr_hold, b_rden, b_wren;
	wire logic [ERB_AW-1:0] a_addr, b_addr;
	wire logic [ERB_BEW-1:0] a_byteena, b_byteena;
	wire logic [ERB_DW-1:0] a_data, b_data, a_q, b_q;
	int fail_count = 0, checked = 0;
	logic [8:0] mem [1024];
	assign a_ce_out = a_ce_in;
	assign b_ce_out = b_ce_in;
	erb_core i_dut (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .a_aclr, .a_ce_in, .a_ce_out,
		.a_addr_hold, .a_addr, .a_rden, .a_wren, .a_byteena, .a_data, .a_q,
		.b_aclr, .b_ce_in, .b_ce_out, .b_addr_hold, .b_addr, .b_rden,
		.b_wren, .b_byteena, .b_data, .b_q);
	erb_fabric i_fa (.clk, .aclr(a_aclr), .ce(a_ce_in), .hold(a_addr_hold),
		.addr(a_addr), .rden(a_rden), .wren(a_wren), .be(a_byteena),
		.data(a_data));
	erb_fabric i_fb (.clk, .aclr(b_aclr), .ce(b_ce_in), .hold(b_addr_hold),
		.addr(b_addr), .rden(b_rden), .wren(b_wren), .be(b_byteena),
		.data(b_data));
	initial forever #50 clk = ~clk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic int bw(int c);
		int t[9] = '{1, 2, 4, 8, 9, 16, 18, 32, 36};
		return t[c];
	endfunction
	function automatic int lw(int c);
		return (bw(c) % 9 == 0) ? 9 : 8;
	endfunction
	// byte index times 16 plus bit index of word bit j
	function automatic int pos(int c, int a, int j);
		if (bw(c) < 8)
			return (a / (8 / bw(c))) * 16 + (a % (8 / bw(c))) * bw(c) + j;
		return (a * (bw(c) / lw(c)) + j / lw(c)) * 16 + j % lw(c);
	endfunction
	task automatic mwr(int c, int a, logic [35:0] d, logic [3:0] m);
		int p;
		for (int j = 0; j < bw(c); j++) begin
			p = pos(c, a, j);
			if (bw(c) < 16 || m[j / lw(c)])
				mem[p / 16][p % 16] = d[j];
		end
	endtask
	function automatic logic [35:0] mrd(int c, int a);
		logic [35:0] r;
		int p;
		r = '0;
		for (int j = 0; j < bw(c); j++) begin
			p = pos(c, a, j);
			r[j] = mem[p / 16][p % 16];
		end
		return r;
	endfunction
	function automatic logic [35:0] cut(int c, logic [35:0] v);
		return v & ((36'h1 << bw(c)) - 36'h1);
	endfunction
	task automatic chk(input string n, input logic [35:0] e, s);
		checked++;
		if (s !== e) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic tally_and_finish();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int i;
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		if (i == 20) begin
			fail_count++;
			tally_and_finish();
		end
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic cfg(int md, int c, logic [31:0] f);
		apb(1, ERB_CFG_OFFSET, 32'(md | c << 2 | c << 6) | f, rv, ev);
	endtask
	initial begin
		repeat (100000) @(posedge clk);
		fail_count++;
		tally_and_finish();
	end
	initial begin
		int c, k, ad[8];
		logic [35:0] d, v, o;
		logic [3:0] m;
		foreach (mem[i]) mem[i] = ERB_INIT_BYTE;
		repeat (6) @(posedge clk);
		resetn <= 1;
		#1 chk("a_q reset", 0, a_q);
		chk("b_q reset", 0, b_q);
		apb(0, ERB_CFG_OFFSET, 0, rv, ev);
		chk("cfg reset", 36'(ERB_CFG_RESET), 36'(rv));
		apb(0, 12'h008, 0, rv, ev);
		chk("unmapped", 1, 36'(ev));
		chk("unmapped data", 0, 36'(rv));
		$display("test bus done");
		for (c = 0; c < 9; c++) begin
			cfg(0, c, 0);
			for (k = 0; k < 8; k++) begin
				ad[k] = rnd() % ((bw(c) % 9 == 0 ? 9216 : 8192) / bw(c));
				d = 36'({rnd(), rnd()});
				m = 4'(rnd());
				i_fa.op(0, 1, 1, 0, 13'(ad[k]), d, m);
				mwr(c, ad[k], d, m);
			end
			for (k = 0; k < 9; k++) begin
				if (k < 8)
					i_fa.op(1, 0, 1, 0, 13'(ad[k]), 0, 4'hf);
				else
					i_fa.idle();
				#1;
				if (k > 0)
					chk("width", mrd(c, ad[k-1]), cut(c, a_q));
			end
		end
		$display("test widths done");
		// read during write, old then new
		cfg(0, 8, 0);
		d = 36'({rnd(), rnd()});
		i_fa.op(0, 1, 1, 0, 5, d, 4'hf);
		mwr(8, 5, d, 4'hf);
		d = 36'({rnd(), rnd()});
		i_fa.op(1, 1, 1, 0, 5, d, 4'h5);
		o = mrd(8, 5);
		mwr(8, 5, d, 4'h5);
		i_fa.idle();
		#1 chk("rdw old", o, a_q);
		cfg(0, 8, 32'h0000_0400);
		d = 36'({rnd(), rnd()});
		i_fa.op(1, 1, 1, 0, 5, d, 4'ha);
		mwr(8, 5, d, 4'ha);
		i_fa.idle();
		#1 chk("rdw new", mrd(8, 5), a_q);
		$display("test read during write done");
		cfg(0, 8, 32'h0000_1000);
		v = mrd(8, 5);
		i_fa.op(0, 1, 1, 0, 6, ~v, 4'hf);
		mwr(8, 6, ~v, 4'hf);
		i_fa.op(1, 0, 1, 0, 6, 0, 4'hf);
		i_fa.idle();
		#1 chk("oreg early", v, a_q);
		@(posedge clk);
		#1 chk("oreg late", ~v, a_q);
		$display("test output register done");
		cfg(0, 8, 0);
		i_fa.op(0, 1, 0, 0, 6, v, 4'hf);
		i_fa.op(1, 0, 1, 0, 6, 0, 4'hf);
		i_fa.op(1, 0, 0, 0, 5, 0, 4'hf);
		i_fa.idle();
		#1 chk("ce off", ~v, a_q);
		i_fa.op(1, 0, 1, 0, 5, 0, 4'hf);
		i_fa.op(1, 0, 1, 1, 6, 0, 4'hf);
		i_fa.idle();
		#1 chk("addr hold", v, a_q);
		i_fa.clr();
		#1 chk("aclr", 0, a_q);
		$display("test enables done");
		cfg(2, 5, 0);
		o = mrd(5, 7);
		d = 36'({rnd(), rnd()});
		fork
			i_fa.op(0, 1, 1, 0, 7, d, 4'hf);
			i_fb.op(1, 0, 1, 0, 7, 0, 4'hf);
		join
		mwr(5, 7, d, 4'hf);
		fork
			i_fa.op(1, 0, 1, 0, 7, 0, 4'hf);
			i_fb.op(1, 0, 1, 0, 7, 0, 4'hf);
		join
		#1 chk("collide", o, cut(5, b_q));
		fork
			i_fa.idle();
			i_fb.idle();
		join
		#1 chk("dual a", mrd(5, 7), cut(5, a_q));
		chk("dual b", mrd(5, 7), cut(5, b_q));
		// collision flag sticky, cleared by writing one
		apb(0, ERB_STAT_OFFSET, 0, rv, ev);
		chk("stat", 36'(32'h0000_000e), 36'(rv));
		apb(1, ERB_STAT_OFFSET, 32'h0000_0002, rv, ev);
		apb(0, ERB_STAT_OFFSET, 0, rv, ev);
		chk("stat clear", 36'(32'h0000_000c), 36'(rv));
		// simple dual, x32 write and x8 read
		apb(1, ERB_CFG_OFFSET, 32'(1 | 7 << 2 | 3 << 6), rv, ev);
		d = 36'({rnd(), rnd()});
		i_fa.op(0, 1, 1, 0, 2, d, 4'hf);
		mwr(7, 2, d, 4'hf);
		i_fa.idle();
		i_fb.op(1, 0, 1, 0, 9, 0, 4'hf);
		i_fb.idle();
		#1 chk("mixed", mrd(3, 9), cut(3, b_q));
		cfg(3, 3, 0);
		fork
			i_fa.op(0, 1, 1, 0, 3, d, 4'hf);
			i_fb.op(0, 1, 1, 0, 3, ~d, 4'hf);
		join
		mwr(3, 3, d, 4'hf);
		mwr(3, 515, ~d, 4'hf);
		fork
			i_fa.op(1, 0, 1, 0, 3, 0, 4'hf);
			i_fb.op(1, 0, 1, 0, 3, 0, 4'hf);
		join
		fork
			i_fa.idle();
			i_fb.idle();
		join
		#1 chk("packed a", mrd(3, 3), cut(3, a_q));
		chk("packed b", mrd(3, 515), cut(3, b_q));
		$display("test dual and packed done");
		tally_and_finish();
	end
endmodule
